//--- core/ext_irq_pkg.sv
// Constants and carrier types for the external interrupt front end.
// Assumes a single clock domain at sys_clk, which is the high-frequency clock.
package ext_irq_pkg;

  // Special function register address space
  localparam int unsigned SFR_ADDR_W = 6;
  localparam logic [5:0]  EXT_CTRL_OFFSET = 6'h37;

  // Control register field positions
  localparam int unsigned FILTER_SEL_BIT = 7;
  localparam int unsigned SHARED_SEL_BIT = 6;
  localparam int unsigned EDGE_SEL_BIT   = 1;

  // Control register reset value; reserved bits read as zero
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Idle pin level captured by synchronisers and filters at reset
  localparam logic [2:0] PIN_IDLE = 3'h7;

  // Clock rates; sys_clk is the high-frequency clock itself
  localparam longint unsigned SYS_CLK_HZ = 64'd20000000;
  localparam longint unsigned FC_HZ      = 64'd20000000;

  // Filter times in high-frequency clock periods
  localparam longint unsigned AC_REJECT_FC     = 64'd2;
  localparam longint unsigned AC_ACCEPT_FC     = 64'd7;
  localparam longint unsigned B_FAST_REJECT_FC = 64'd15;
  localparam longint unsigned B_FAST_ACCEPT_FC = 64'd49;
  localparam longint unsigned B_SLOW_REJECT_FC = 64'd63;
  localparam longint unsigned B_SLOW_ACCEPT_FC = 64'd193;
  localparam longint unsigned THRESH_SETTLE_FC = 64'd64;

  // Latch set slack after signal establishment, in low-frequency periods
  localparam int unsigned LATCH_SLACK_FS = 6;

  // Qualifying counts: least stable time, rounded up to whole cycles
  localparam logic [7:0] AC_QUAL_CYC =
    8'((AC_REJECT_FC * SYS_CLK_HZ + FC_HZ - 64'd1) / FC_HZ);
  localparam logic [7:0] B_FAST_QUAL_CYC =
    8'((B_FAST_REJECT_FC * SYS_CLK_HZ + FC_HZ - 64'd1) / FC_HZ);
  localparam logic [7:0] B_SLOW_QUAL_CYC =
    8'((B_SLOW_REJECT_FC * SYS_CLK_HZ + FC_HZ - 64'd1) / FC_HZ);

  // Shortest surely accepted pulse widths and threshold settle time, rounded down
  localparam logic [7:0] AC_ACCEPT_CYC =
    8'((AC_ACCEPT_FC * SYS_CLK_HZ) / FC_HZ);
  localparam logic [7:0] B_FAST_ACCEPT_CYC =
    8'((B_FAST_ACCEPT_FC * SYS_CLK_HZ) / FC_HZ);
  localparam logic [7:0] B_SLOW_ACCEPT_CYC =
    8'((B_SLOW_ACCEPT_FC * SYS_CLK_HZ) / FC_HZ);
  localparam logic [7:0] THRESH_SETTLE_CYC =
    8'((THRESH_SETTLE_FC * SYS_CLK_HZ) / FC_HZ);

  // Channel indices
  localparam int unsigned CH_A = 0;
  localparam int unsigned CH_B = 1;
  localparam int unsigned CH_C = 2;

  // Register access request from the CPU side
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

  // Control fields held by the block
  typedef struct packed {
    logic irq_b_filter_select;
    logic shared_pin_irq_select;
    logic irq_b_edge_select;
  } ext_ctrl_t;

  // Interrupt latch clear strobes from the interrupt logic, one per source
  typedef struct packed {
    logic irq_c;
    logic irq_b;
    logic irq_a;
  } irq_clear_t;

endpackage : ext_irq_pkg

//--- core/external_interrupt_frontend.sv
// External interrupt front end: noise filters, edge select, shared pin role
// and the three interrupt latches, with the control register on the SFR port.
// Assumes pins are asynchronous, the SFR strobes and latch clears come from
// logic on sys_clk, and acceptance and priority are handled elsewhere.
`timescale 1ns/1ps

// Functional notes
// - Three inputs, each noise filtered before latching
// - A and C: falling edge, 2/7 fc thresholds
// - B rejects below 15 or 63 fc
// - Bit 7 picks B threshold, 1 is short
// - Bit 1 picks B edge, 1 is falling
// - Bit 6 gives shared pin interrupt role
// - Pin role bit 0 blocks A latch
// - Reset: port role, control bits zero
// - Latch set soon after signal establishment
// - New threshold acts within 64 fc
// - Own output changes can raise false requests
module external_interrupt_frontend #(
  parameter int unsigned CNT_W = 8
) (
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 srst,
  // Special function register port
  input  wire ext_irq_pkg::sfr_req_t sfr_req,
  output logic [7:0]                sfr_rdata,
  output logic                      sfr_rvalid,
  // External interrupt pins
  input  wire logic                 ext_irq_a,
  input  wire logic                 ext_irq_b,
  input  wire logic                 ext_irq_c,
  // Port read path for the shared pin
  output logic                      shared_port_line,
  // Latch clears from the interrupt acceptance logic
  input  wire ext_irq_pkg::irq_clear_t latch_clear,
  // Interrupt latches and control view
  output logic                      irq_a_latch,
  output logic                      irq_b_latch,
  output logic                      irq_c_latch,
  output ext_irq_pkg::ext_ctrl_t    ctrl_view
);

  // Refuse a counter too narrow for the longest qualifying count
  if (CNT_W < 8 || (2 ** CNT_W) <= int'(ext_irq_pkg::B_SLOW_QUAL_CYC)) begin : g_width_check
    $error("CNT_W too small for the filter thresholds");
  end

  // Refuse package figures the filters cannot honour: each qualifying
  // count must be above zero and no longer than the shortest sure pulse
  if (ext_irq_pkg::AC_QUAL_CYC == 8'h00 ||
      ext_irq_pkg::AC_QUAL_CYC > ext_irq_pkg::AC_ACCEPT_CYC) begin : g_ac_check
    $error("A and C qualifying count out of range");
  end

  // Channel B short threshold against its sure-signal width
  if (ext_irq_pkg::B_FAST_QUAL_CYC == 8'h00 ||
      ext_irq_pkg::B_FAST_QUAL_CYC > ext_irq_pkg::B_FAST_ACCEPT_CYC) begin : g_bf_check
    $error("B short qualifying count out of range");
  end

  // Channel B long threshold against its sure-signal width
  if (ext_irq_pkg::B_SLOW_QUAL_CYC == 8'h00 ||
      ext_irq_pkg::B_SLOW_QUAL_CYC > ext_irq_pkg::B_SLOW_ACCEPT_CYC) begin : g_bs_check
    $error("B long qualifying count out of range");
  end

  // The threshold is read live, so one cycle must fit the settle allowance
  if (ext_irq_pkg::THRESH_SETTLE_CYC == 8'h00) begin : g_settle_check
    $error("threshold settle time too short");
  end

  // The register port carries a fixed six-bit address
  if (ext_irq_pkg::SFR_ADDR_W != 6) begin : g_addr_check
    $error("register address width must be six");
  end

  // Control fields must be distinct bits of one byte
  if (ext_irq_pkg::FILTER_SEL_BIT > 7 ||
      ext_irq_pkg::SHARED_SEL_BIT > 7 ||
      ext_irq_pkg::EDGE_SEL_BIT > 7 ||
      ext_irq_pkg::FILTER_SEL_BIT == ext_irq_pkg::SHARED_SEL_BIT ||
      ext_irq_pkg::FILTER_SEL_BIT == ext_irq_pkg::EDGE_SEL_BIT ||
      ext_irq_pkg::SHARED_SEL_BIT == ext_irq_pkg::EDGE_SEL_BIT) begin : g_field_check
    $error("control field positions clash");
  end

  // Timing of one channel, counted in sys_clk edges from a pin change:
  //   edge 1      first synchroniser stage takes the new level
  //   edge 2      second stage holds it; the count may start
  //   edges 3..   counter runs while the synchronised level differs
  //   edge Q+2    filtered level moves and the latch is set together
  // A return to the filtered level at any point restarts the count, so a
  // pulse must stand for Q whole sampled cycles to be seen at all.
  // Channel B picks Q from the threshold bit every cycle; a new setting
  // therefore acts on the very next count step.
  // A filtered falling edge needs the filtered level high first, so after
  // an accepted low pulse the pin must again stand high for Q cycles
  // before the next pulse can be taken.
  // Latch clears from the acceptance logic lose against a new edge in the
  // same cycle, so no request is dropped between clear and set.
  // The shared pin is always visible on the port read path after its
  // synchroniser; only its latch is gated by the pin-role bit.

  // Complete block state in one register
  typedef struct packed {
    logic [2:0]            sync_a;    // First synchroniser stage
    logic [2:0]            sync_b;    // Second synchroniser stage
    logic [2:0]            level;     // Filtered levels
    logic [2:0][CNT_W-1:0] count;     // Stable-level counters
    ext_irq_pkg::ext_ctrl_t ctrl;     // Control fields
    logic [2:0]            latch;     // Interrupt latches
    logic [7:0]            rdata;     // Read data
    logic                  rvalid;    // Read data valid
  } state_t;

  state_t state;
  state_t next_state;

  // Raw pins gathered in channel order
  logic [2:0] pin_raw;
  assign pin_raw = {ext_irq_c, ext_irq_b, ext_irq_a};

  // Clear strobes gathered in channel order
  logic [2:0] clear_vec;
  assign clear_vec = {latch_clear.irq_c, latch_clear.irq_b, latch_clear.irq_a};

  // Register hit decode
  logic ctrl_hit;
  assign ctrl_hit = (sfr_req.addr == ext_irq_pkg::EXT_CTRL_OFFSET);

  // Control register image as read back
  function automatic logic [7:0] ctrl_image(input ext_irq_pkg::ext_ctrl_t c);
    logic [7:0] img;
    img = 8'h00;
    img[ext_irq_pkg::FILTER_SEL_BIT] = c.irq_b_filter_select;
    img[ext_irq_pkg::SHARED_SEL_BIT] = c.shared_pin_irq_select;
    img[ext_irq_pkg::EDGE_SEL_BIT]   = c.irq_b_edge_select;
    return img;
  endfunction : ctrl_image

  // Qualifying count of a channel; channel B follows the threshold bit
  function automatic logic [CNT_W-1:0] qual_count(input int unsigned ch,
                                                  input logic fast_sel);
    logic [CNT_W-1:0] q;
    q = CNT_W'(ext_irq_pkg::AC_QUAL_CYC);
    if (ch == ext_irq_pkg::CH_B) begin
      // Read live each cycle, so a new setting acts on the next edge
      if (fast_sel) begin
        q = CNT_W'(ext_irq_pkg::B_FAST_QUAL_CYC);
      end else begin
        q = CNT_W'(ext_irq_pkg::B_SLOW_QUAL_CYC);
      end
    end
    return q;
  endfunction : qual_count

  // Qualifying count per channel, one selection per channel
  logic [2:0][CNT_W-1:0] qual_cnt;
  for (genvar ch = 0; ch < 3; ch++) begin : g_qual
    // Channel B follows the threshold bit; the others are fixed
    assign qual_cnt[ch] = qual_count(ch, state.ctrl.irq_b_filter_select);
  end

  // Filter edges and latch conditions
  logic [2:0] edge_rise;
  logic [2:0] edge_fall;
  logic [2:0] edge_hit;

  // Next-state logic for synchronisers, filters, latches and registers
  always_comb begin
    next_state = state;

    // Two-stage synchroniser; first stage feeds only the second
    next_state.sync_a = pin_raw;
    next_state.sync_b = state.sync_a;

    // Stable-count filter per channel
    edge_rise = 3'h0;
    edge_fall = 3'h0;
    for (int unsigned ch = 0; ch < 3; ch++) begin
      if (state.sync_b[ch] == state.level[ch]) begin
        // Any glitch back to the filtered level restarts the count
        next_state.count[ch] = '0;
      end else if (state.count[ch] + CNT_W'(1) >= qual_cnt[ch]) begin
        // New level held long enough: accept it
        next_state.level[ch] = state.sync_b[ch];
        next_state.count[ch] = '0;
        edge_rise[ch]        = state.sync_b[ch];
        edge_fall[ch]        = ~state.sync_b[ch];
      end else begin
        next_state.count[ch] = state.count[ch] + CNT_W'(1);
      end
    end

    // Edge selection per channel
    edge_hit[ext_irq_pkg::CH_A] = edge_fall[ext_irq_pkg::CH_A] &
                                  state.ctrl.shared_pin_irq_select;
    edge_hit[ext_irq_pkg::CH_B] = state.ctrl.irq_b_edge_select ?
                                  edge_fall[ext_irq_pkg::CH_B] :
                                  edge_rise[ext_irq_pkg::CH_B];
    edge_hit[ext_irq_pkg::CH_C] = edge_fall[ext_irq_pkg::CH_C];

    // Latches: set on the same edge as acceptance, set wins over clear
    for (int unsigned ch = 0; ch < 3; ch++) begin
      if (edge_hit[ch]) begin
        next_state.latch[ch] = 1'b1;
      end else if (clear_vec[ch]) begin
        next_state.latch[ch] = 1'b0;
      end
    end

    // Control register write; reserved bits are dropped
    if (sfr_req.wr && ctrl_hit) begin
      next_state.ctrl.irq_b_filter_select   = sfr_req.wdata[ext_irq_pkg::FILTER_SEL_BIT];
      next_state.ctrl.shared_pin_irq_select = sfr_req.wdata[ext_irq_pkg::SHARED_SEL_BIT];
      next_state.ctrl.irq_b_edge_select     = sfr_req.wdata[ext_irq_pkg::EDGE_SEL_BIT];
    end

    // Read answer one cycle after the strobe; other addresses read zero
    next_state.rvalid = sfr_req.rd;
    if (sfr_req.rd && ctrl_hit) begin
      next_state.rdata = ctrl_image(state.ctrl);
    end else if (sfr_req.rd) begin
      next_state.rdata = 8'h00;
    end
  end

  // State register with synchronous reset to constant values only
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      // Pins idle high, so filters start at the idle level: no false edge
      state.sync_a <= ext_irq_pkg::PIN_IDLE;
      state.sync_b <= ext_irq_pkg::PIN_IDLE;
      state.level  <= ext_irq_pkg::PIN_IDLE;
      state.count  <= '0;
      // Shared pin comes up in its port role, short threshold off
      state.ctrl.irq_b_filter_select <=
        ext_irq_pkg::CTRL_RESET[ext_irq_pkg::FILTER_SEL_BIT];
      state.ctrl.shared_pin_irq_select <=
        ext_irq_pkg::CTRL_RESET[ext_irq_pkg::SHARED_SEL_BIT];
      state.ctrl.irq_b_edge_select <=
        ext_irq_pkg::CTRL_RESET[ext_irq_pkg::EDGE_SEL_BIT];
      // No pending requests and no read answer
      state.latch  <= 3'h0;
      state.rdata  <= 8'h00;
      state.rvalid <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // Outputs straight from the state register
  assign sfr_rdata  = state.rdata;
  assign sfr_rvalid = state.rvalid;
  assign irq_a_latch = state.latch[ext_irq_pkg::CH_A];
  assign irq_b_latch = state.latch[ext_irq_pkg::CH_B];
  assign irq_c_latch = state.latch[ext_irq_pkg::CH_C];
  assign ctrl_view   = state.ctrl;

  // Synchronised shared pin level; it also sees the port's own drive
  assign shared_port_line = state.sync_b[ext_irq_pkg::CH_A];

endmodule : external_interrupt_frontend

//--- test/ext_irq_props.sv
// Checker for the external interrupt front end, bound to its top module.
// Assumes one clock domain and pins that idle high.
`timescale 1ns/1ps
module ext_irq_props #(
  parameter int unsigned CNT_W = 8
) (
  // Clock, reset and register port
  input wire logic                    sys_clk, srst,
  input wire ext_irq_pkg::sfr_req_t   sfr_req,
  input wire logic [7:0]              sfr_rdata,
  input wire logic                    sfr_rvalid, shared_port_line,
  // Pins, clears, latches and control view
  input wire logic                    ext_irq_a, ext_irq_b, ext_irq_c,
  input wire ext_irq_pkg::irq_clear_t latch_clear,
  input wire logic                    irq_a_latch, irq_b_latch, irq_c_latch,
  input wire ext_irq_pkg::ext_ctrl_t  ctrl_view
);
  localparam logic [5:0] OFS = ext_irq_pkg::EXT_CTRL_OFFSET;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  // Register writes and reads
  ctrl_write_a:
    assert property (sfr_req.wr && sfr_req.addr == OFS |=>
      ctrl_view == {$past(sfr_req.wdata[7]), $past(sfr_req.wdata[6]), $past(sfr_req.wdata[1])})
    else $error("control write not taken");
  read_image_a:
    assert property (sfr_rvalid && $past(sfr_req.addr) == OFS |->
      sfr_rdata == {ctrl_view[2:1], 4'h0, ctrl_view[0], 1'h0})
    else $error("control read image wrong");
  read_valid_a:
    assert property (sfr_req.rd |=> sfr_rvalid) else $error("read not answered");
  // Pin role, filters and latches
  port_gate_a:
    assert property (!ctrl_view.shared_pin_irq_select && !$past(ctrl_view.shared_pin_irq_select)
      |-> !$rose(irq_a_latch)) else $error("latch a set in port role");
  port_follow_a:
    assert property ($stable(ext_irq_a)[*5] |-> shared_port_line == ext_irq_a)
    else $error("shared line does not follow pin");
  c_filter_a:
    assert property ($rose(irq_c_latch) |-> !$past(ext_irq_c, 3) &&
      !$past(ext_irq_c, 4)) else $error("latch c on short pulse");
  b_fast_filter_a:
    assert property ($rose(irq_b_latch) && ctrl_view == 3'h7 |->
      !$past(ext_irq_b, 3) && !$past(ext_irq_b, 17)) else $error("latch b on short pulse");
  latch_hold_a:
    assert property (irq_b_latch && !latch_clear.irq_b |=> irq_b_latch)
    else $error("latch b dropped");
  cover property ($rose(irq_a_latch));
  cover property ($rose(irq_b_latch));
  cover property ($rose(irq_c_latch));
endmodule : ext_irq_props

bind external_interrupt_frontend ext_irq_props #(.CNT_W(CNT_W)) props (.sys_clk, .srst,
  .sfr_req, .sfr_rdata, .sfr_rvalid, .shared_port_line, .ext_irq_a, .ext_irq_b, .ext_irq_c,
  .latch_clear, .irq_a_latch, .irq_b_latch, .irq_c_latch, .ctrl_view);

//--- test/irq_pin_source.sv
// External signal sources for the three interrupt pins.
// Assumes the bench calls its tasks; pins idle high between pulses.
`timescale 1ns/1ps
module irq_pin_source (
  // Clock
  input wire logic sys_clk,
  // Pins, only ever driven from outside, so the shared line stays an input
  output logic     pin_a, pin_b, pin_c
);
  logic [2:0] lvl = 3'h7;
  assign {pin_c, pin_b, pin_a} = lvl;
  // Set one pin just after an edge
  task automatic set_pin(input int ch, input logic v);
    @(posedge sys_clk) #1 lvl[ch] = v;
  endtask : set_pin
  // Low pulse lasting w clock periods
  task automatic pulse(input int ch, input int w);
    set_pin(ch, 1'b0);
    repeat (w) @(posedge sys_clk);
    #1 lvl[ch] = 1'b1;
  endtask : pulse
endmodule : irq_pin_source

//--- test/testbench.sv
// Self-checking bench for the external interrupt front end.
// Assumes the checker is bound and the pin source drives all three pins.
`timescale 1ns/1ps
module testbench;
  logic                    sys_clk = 1'b0, srst = 1'b1;
  ext_irq_pkg::sfr_req_t   sfr_req = '0;
  ext_irq_pkg::irq_clear_t latch_clear = '0;
  ext_irq_pkg::ext_ctrl_t  ctrl_view;
  logic [7:0]              sfr_rdata;
  logic                    sfr_rvalid, shared_port_line, ext_irq_a, ext_irq_b, ext_irq_c;
  logic                    irq_a_latch, irq_b_latch, irq_c_latch;
  int                      bad_count = 0, n_compared = 0;
  // Clock at 50 ns period
  initial forever #25 sys_clk = ~sys_clk;
  external_interrupt_frontend #(.CNT_W(8)) dut (.sys_clk, .srst, .sfr_req, .sfr_rdata,
    .sfr_rvalid, .ext_irq_a, .ext_irq_b, .ext_irq_c, .shared_port_line, .latch_clear,
    .irq_a_latch, .irq_b_latch, .irq_c_latch, .ctrl_view);
  irq_pin_source src (.sys_clk, .pin_a(ext_irq_a), .pin_b(ext_irq_b), .pin_c(ext_irq_c));
  // Compare tasks for bits and bytes
  task automatic chk1(input string nm, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s exp %b got %b", nm, e, g);
    end
  endtask : chk1
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk8
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : step
  // Register writes and reads, made while the pins are idle
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge sys_clk) #1 sfr_req = '{1'b1, 1'b0, a, d};
    @(posedge sys_clk) #1 sfr_req = '0;
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    @(posedge sys_clk) #1 sfr_req = '{1'b0, 1'b1, a, 8'h00};
    @(posedge sys_clk) #1 sfr_req = '0;
    chk1("rvalid", 1'b1, sfr_rvalid);
    chk8("rdata", e, sfr_rdata);
  endtask : rd
  // Pulse a pin, check its latch, then clear it by strobe only
  task automatic try(input int ch, input int w, input logic e);
    logic [2:0] l;
    src.pulse(ch, w);
    step(w + 8);
    l = {irq_c_latch, irq_b_latch, irq_a_latch};
    chk1("latch", e, l[ch]);
    latch_clear[ch] = 1'b1;
    step(1);
    latch_clear = '0;
    l = {irq_c_latch, irq_b_latch, irq_a_latch};
    chk1("cleared", 1'b0, l[ch]);
  endtask : try
  task automatic end_sim();
    $display("compared %0d bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim
  // Run limit
  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    end_sim();
  end
  // Main sequence
  initial begin
    step(2);
    srst = 1'b0;
    rd(6'h37, 8'h00);
    chk1("port", 1'b1, shared_port_line);
    wr(6'h36, 8'hFF);
    rd(6'h37, 8'h00);
    rd(6'h36, 8'h00);
    src.set_pin(0, 1'b0);
    step(6);
    chk1("port", 1'b0, shared_port_line);
    src.set_pin(0, 1'b1);
    step(6);
    chk1("latch", 1'b0, irq_a_latch);
    try(0, 7, 1'b0);
    wr(6'h37, 8'h40);
    try(0, 7, 1'b1);
    try(0, 1, 1'b0);
    try(2, 7, 1'b1);
    try(2, 1, 1'b0);
    wr(6'h37, 8'hFF);
    rd(6'h37, 8'hC2);
    try(1, 14, 1'b0);
    try(1, 15, 1'b1);
    try(1, 49, 1'b1);
    wr(6'h37, 8'h42);
    try(1, 62, 1'b0);
    try(1, 63, 1'b1);
    wr(6'h37, 8'h40);
    src.set_pin(1, 1'b0);
    step(70);
    chk1("latch", 1'b0, irq_b_latch);
    src.set_pin(1, 1'b1);
    step(70);
    chk1("latch", 1'b1, irq_b_latch);
    wr(6'h37, 8'hC2);
    srst = 1'b1;
    step(2);
    srst = 1'b0;
    chk1("latch", 1'b0, irq_b_latch);
    rd(6'h37, 8'h00);
    end_sim();
  end
endmodule : testbench
